//--- src/hptw_pkg.sv
// hptw_pkg: constants for the hashed page table walker.
// assumes a wishbone register slave and a separate memory read port.
package hptw_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets as byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DESC_LO   = 8'h00;
  localparam logic [7:0] ADDR_DESC_HI   = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h10;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h14;

  localparam int CTRL_WIDE_BIT   = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_HIT_BIT    = 1;
  localparam int STAT_FAULT_BIT  = 2;
  localparam int STAT_SECOND_BIT = 3;

  localparam logic [63:0] DESC_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // descriptor fields, bit 0 = msb numbering mapped to lsb indices
  // ----------------------------------------------------------------
  localparam int WIDE_ORG_LSB   = 18;   // 46-bit origin, bits 63:18
  localparam int WIDE_SIZE_W    = 5;    // size code in bits 4:0
  localparam int WIDE_MASK_W    = 28;
  localparam int WIDE_MIN_IDX   = 11;
  localparam int WIDE_HASH_W    = 39;
  localparam int WIDE_GRP_SHIFT = 7;    // 128-byte groups
  localparam int WIDE_ENT_SHIFT = 4;    // 16-byte entries
  localparam int NARR_ORG_LSB   = 16;   // 16-bit origin, bits 31:16
  localparam int NARR_MASK_W    = 9;    // index mask in bits 8:0
  localparam int NARR_MIN_IDX   = 10;
  localparam int NARR_HASH_W    = 19;
  localparam int NARR_GRP_SHIFT = 6;    // 64-byte groups
  localparam int NARR_ENT_SHIFT = 3;    // 8-byte entries
  localparam int GROUP_ENTRIES  = 8;

  typedef enum logic [1:0] {
    HPTW_IDLE,
    HPTW_READ,
    HPTW_WAIT,
    HPTW_DONE
  } hptw_state_t;

endpackage

//--- src/hptw_walker.sv
// hptw_walker: hashed page table search engine with wishbone registers.
// assumes memory answers each read with mem_valid_i, coherent, physical.
`timescale 1ns/1ns

// Functional notes
// RQ1 - on a buffer miss, search the hashed table in memory
// RQ2 - table reads use physical addresses with coherency flag always set
// RQ3 - software searches only with data relocation off
// RQ4 - table size is a power of two, base aligned to it
// RQ5 - groups hold eight entries: 16/128 bytes wide, 8/64 bytes narrow
// RQ6 - all sixteen slots across both groups are searched
// RQ7 - no match in either group reports a page fault
// RQ8 - primary hash joined with descriptor origin forms primary group address
// RQ9 - entries within a group are examined one at a time
// RQ10 - primary miss computes secondary hash and rescans there
// RQ11 - wide descriptor: origin 0-45, reserved 46-58, size code 59-63
// RQ12 - wide origin gives upper 46 bits, 256 Kbyte alignment minimum
// RQ13 - software zeros unsupported origin bits
// RQ14 - size code expands to 28-bit mask of trailing ones
// RQ15 - wide origin low bits cleared to match mask ones
// RQ16 - narrow descriptor: origin 0-15, reserved 16-22, mask 23-31
// RQ17 - narrow origin gives upper 16 bits, 64 Kbyte alignment minimum
// RQ18 - narrow mask is zeros then ones, selecting hash bits beyond 10
// RQ19 - narrow origin low bits cleared to match mask ones
// RQ20 - wide table is at least 256 Kbytes
// RQ21 - table should have half as many groups as page frames
// RQ22 - wide primary hash xors segment id with zero-extended page index
// RQ23 - secondary hash is the complement of the primary
// RQ24 - origin ORed with masked hash bits forms group address
// RQ25 - hit needs valid, matching id, page index and hash-select flag
// RQ26 - hit loads buffer and resumes; miss raises storage fault
module hptw_walker
#(
  parameter int PA_W = 64
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // miss request from translation buffer
  input  wire logic              miss_valid_i,
  input  wire logic              miss_instr_i,
  input  wire logic [38:0]       miss_segment_identifier_i,
  input  wire logic [15:0]       miss_page_index_i,
  output logic                   miss_ready_o,
  // memory read port
  output logic                   mem_req_o,
  output logic      [PA_W-1:0]   mem_addr_o,
  output logic                   mem_coherent_o,
  input  wire logic              mem_valid_i,
  input  wire logic [127:0]      mem_data_i,
  // results
  output logic                   fill_valid_o,
  output logic      [63:0]       fill_entry_o,
  output logic                   resume_o,
  output logic                   fault_instr_o,
  output logic                   fault_data_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0]              desc;
    logic                     wide;
    hptw_pkg::hptw_state_t    st;
    logic [38:0]              sid;
    logic [15:0]              pidx;
    logic                     instr;
    logic                     second;
    logic [2:0]               slot;
    logic [PA_W-1:0]          group;
    logic                     busy;
    logic                     hit;
    logic                     fault;
    logic [63:0]              result;
    logic [31:0]              dat;
    logic                     ack;
    logic                     ready;
    logic                     req;
    logic [PA_W-1:0]          addr;
    logic                     fill;
    logic                     resume;
    logic                     f_i;
    logic                     f_d;
  } hptw_regs_t;

  hptw_regs_t r;
  hptw_regs_t next_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [27:0] hptw_size_mask(input logic [4:0] code);
    logic [27:0] m;
    m = '0;
    for (int i = 0; i < hptw_pkg::WIDE_MASK_W; i++)
    begin
      if (i < int'(code))
        m[i] = 1'b1;
    end
    return m; // RQ14
  endfunction

  // group address from hash, origin and mask
  function automatic logic [PA_W-1:0] hptw_group_addr(input logic wide, input logic [63:0] d,
                                                     input logic [38:0] hash);
    logic [63:0] a;
    logic [27:0] m;
    a = '0;
    m = '0;
    if (wide)
    begin
      m = hptw_size_mask(d[4:0]);
      a[63:18] = d[63:18] | {18'h00000, hash[38:11] & m}; // RQ24 RQ12
      a[17:7]  = hash[10:0]; // RQ8
    end
    else
    begin
      m[8:0] = d[8:0]; // RQ18
      a[31:16] = d[31:16] | {7'h00, hash[18:10] & m[8:0]}; // RQ24 RQ17
      a[15:6]  = hash[9:0];
    end
    return a[PA_W-1:0];
  endfunction

  // entry offset inside a group; slot stays below the group size
  function automatic logic [PA_W-1:0] hptw_slot_offset(input logic wide, input logic [2:0] slot);
    logic [PA_W-1:0] o;
    o = '0;
    if (wide)
      o[hptw_pkg::WIDE_ENT_SHIFT +: 3] = slot; // RQ5
    else
      o[hptw_pkg::NARR_ENT_SHIFT +: 3] = slot; // RQ5
    return o;
  endfunction

  logic [38:0]     hash1;
  logic [63:0]     ent_hi;
  logic [63:0]     ent_lo;
  logic            match;
  logic [PA_W-1:0] grp_addr;

  always_comb
  begin
    if (r.wide)
      hash1 = r.sid ^ {23'h000000, r.pidx}; // RQ22
    else
      hash1 = {20'h00000, r.sid[18:0] ^ {3'h0, r.pidx}};
    ent_hi = mem_data_i[127:64];
    ent_lo = mem_data_i[63:0];
    // secondary group uses the complemented hash
    grp_addr = hptw_group_addr(r.wide, r.desc, r.second ? ~hash1 : hash1); // RQ23
    // narrow entry sits in ent_hi[63:32] / [31:0]; wide in ent_hi / ent_lo
    if (r.wide)
      match = ent_hi[0] && (ent_hi[1] == r.second)
              && (ent_hi[63:12] == {r.sid[38:0], r.pidx[15:3]}); // RQ25
    else
      match = ent_hi[63] && (ent_hi[57] == r.second)
              && (ent_hi[61:58] == r.pidx[15:12])
              && (ent_hi[56:38] == r.sid[18:0]); // RQ25
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r        = r;
    next_r.ack    = 1'b0;
    next_r.fill   = 1'b0;
    next_r.resume = 1'b0;
    next_r.f_i    = 1'b0;
    next_r.f_d    = 1'b0;

    // bus slave, one wait state, unmapped reads give zero
    // ack low for a cycle between transfers, so a held strobe is not taken twice
    if (wb_cyc_i && wb_stb_i && !r.ack)
    begin
      next_r.ack = 1'b1;
      next_r.dat = 32'h0000_0000;
      if (wb_adr_i == hptw_pkg::ADDR_DESC_LO)
      begin
        if (wb_we_i)
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
              next_r.desc[b*8 +: 8] = wb_dat_i[b*8 +: 8];
          end
        end
        next_r.dat = r.desc[31:0];
      end
      else if (wb_adr_i == hptw_pkg::ADDR_DESC_HI)
      begin
        if (wb_we_i)
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
              next_r.desc[32 + b*8 +: 8] = wb_dat_i[b*8 +: 8];
          end
        end
        next_r.dat = r.desc[63:32];
      end
      else if (wb_adr_i == hptw_pkg::ADDR_CTRL)
      begin
        if (wb_we_i && wb_sel_i[0] && !r.busy)
          next_r.wide = wb_dat_i[hptw_pkg::CTRL_WIDE_BIT];
        next_r.dat[hptw_pkg::CTRL_WIDE_BIT] = r.wide;
      end
      else if (wb_adr_i == hptw_pkg::ADDR_STATUS)
      begin
        next_r.dat[hptw_pkg::STAT_BUSY_BIT]   = r.busy;
        next_r.dat[hptw_pkg::STAT_HIT_BIT]    = r.hit;
        next_r.dat[hptw_pkg::STAT_FAULT_BIT]  = r.fault;
        next_r.dat[hptw_pkg::STAT_SECOND_BIT] = r.second;
      end
      else if (wb_adr_i == hptw_pkg::ADDR_RESULT_LO)
        next_r.dat = r.result[31:0];
      else if (wb_adr_i == hptw_pkg::ADDR_RESULT_HI)
        next_r.dat = r.result[63:32];
    end

    // reserved descriptor bits read back zero
    // set the mode before the descriptor: a switch clears the new layout's reserved bits
    if (r.wide)
      next_r.desc[17:5] = 13'h0000; // RQ11
    else
    begin
      next_r.desc[63:32] = 32'h0000_0000;
      next_r.desc[15:9]  = 7'h00; // RQ16
    end

    case (r.st)
      hptw_pkg::HPTW_IDLE:
      begin
        // ready drops for the whole walk; a new miss waits until the walk ends
        next_r.ready = 1'b1;
        if (miss_valid_i && r.ready)
        begin
          next_r.ready  = 1'b0;
          next_r.sid    = miss_segment_identifier_i; // RQ1
          next_r.pidx   = miss_page_index_i;
          next_r.instr  = miss_instr_i;
          next_r.second = 1'b0;
          next_r.slot   = 3'h0;
          next_r.busy   = 1'b1;
          next_r.hit    = 1'b0;
          next_r.fault  = 1'b0;
          next_r.st     = hptw_pkg::HPTW_READ;
        end
      end
      hptw_pkg::HPTW_READ:
      begin
        next_r.group = grp_addr; // RQ8
        next_r.req   = 1'b1;
        next_r.st    = hptw_pkg::HPTW_WAIT;
        next_r.addr  = grp_addr | hptw_slot_offset(r.wide, r.slot); // RQ5 RQ2
      end
      hptw_pkg::HPTW_WAIT:
      begin
        // data only looked at while mem_valid_i stands; memory latency is open
        if (mem_valid_i)
        begin
          next_r.req = 1'b0;
          if (match)
          begin
            next_r.result = r.wide ? ent_lo : {32'h0000_0000, ent_hi[31:0]};
            next_r.hit    = 1'b1;
            next_r.fill   = 1'b1; // RQ26
            next_r.resume = 1'b1;
            next_r.st     = hptw_pkg::HPTW_DONE;
          end
          else if (r.slot != 3'h7)
          begin
            next_r.slot = r.slot + 3'h1; // RQ9
            next_r.st   = hptw_pkg::HPTW_READ;
          end
          else if (!r.second)
          begin
            next_r.second = 1'b1; // RQ10 RQ6
            next_r.slot   = 3'h0;
            next_r.st     = hptw_pkg::HPTW_READ;
          end
          else
          begin
            next_r.fault = 1'b1; // RQ7
            next_r.f_i   = r.instr; // RQ26
            next_r.f_d   = !r.instr;
            next_r.st    = hptw_pkg::HPTW_DONE;
          end
        end
      end
      hptw_pkg::HPTW_DONE:
      begin
        next_r.busy = 1'b0;
        next_r.st   = hptw_pkg::HPTW_IDLE;
      end
      default:
        next_r.st = hptw_pkg::HPTW_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r      <= '0;
      r.desc <= hptw_pkg::DESC_RESET;
      r.st   <= hptw_pkg::HPTW_IDLE;
    end
    else if (ce_i)
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o       = r.dat;
  assign wb_ack_o       = r.ack;
  assign miss_ready_o   = r.ready;
  assign mem_req_o      = r.req;
  assign mem_addr_o     = r.addr;
  assign mem_coherent_o = r.req; // RQ2
  assign fill_valid_o   = r.fill;
  assign fill_entry_o   = r.result;
  assign resume_o       = r.resume;
  assign fault_instr_o  = r.f_i;
  assign fault_data_o   = r.f_d;

endmodule

//--- testbench/hptw_walker_assertions.sv
// hptw_walker_assertions: port-level checks of the walker.
// assumes one clock domain; ce_i only drops while the walker is idle.
`timescale 1ns/1ns
module hptw_walker_assertions
#(
  parameter int PA_W = 64
)
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  input wire logic            miss_valid_i,
  input wire logic            miss_ready_o,
  input wire logic            mem_req_o,
  input wire logic [PA_W-1:0] mem_addr_o,
  input wire logic            mem_coherent_o,
  input wire logic            mem_valid_i,
  input wire logic            fill_valid_o,
  input wire logic            resume_o,
  input wire logic            fault_instr_o,
  input wire logic            fault_data_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire answer = fill_valid_o || fault_instr_o || fault_data_o;
  a_coherent_req: assert property (mem_req_o |-> mem_coherent_o) else $error("read without coherency");
  a_req_held: assert property (mem_req_o && !mem_valid_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("read dropped or moved");
  a_one_read: assert property (mem_req_o && mem_valid_i |=> !mem_req_o) else $error("overlapping reads");
  a_entry_aligned: assert property (mem_req_o |-> mem_addr_o[2:0] == 3'h0) else $error("misaligned entry");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_fill_resume: assert property (fill_valid_o |-> resume_o) else $error("fill without resume");
  a_fault_alone: assert property (fault_instr_o |-> !fault_data_o && !fill_valid_o)
    else $error("fault clash");
  a_taken_busy: assert property (ce_i && miss_valid_i && miss_ready_o |=> !miss_ready_o)
    else $error("ready while busy");
  a_answer_read: assert property (answer |-> $past(mem_valid_i)) else $error("answer without read");
  a_ready_back: assert property (answer |-> ##[1:3] miss_ready_o) else $error("ready not back");
  c_fill: cover property (fill_valid_o);
  c_fault_d: cover property (fault_data_o);
  c_fault_i: cover property (fault_instr_o);
endmodule

bind hptw_walker hptw_walker_assertions #(.PA_W(PA_W)) hptw_walker_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .miss_valid_i(miss_valid_i),
  .miss_ready_o(miss_ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_coherent_o(mem_coherent_o),
  .mem_valid_i(mem_valid_i), .fill_valid_o(fill_valid_o), .resume_o(resume_o), .fault_instr_o(fault_instr_o),
  .fault_data_o(fault_data_o));

//--- testbench/hptw_mem_model.sv
// hptw_mem_model: table memory; one hit entry, decoys everywhere else.
// assumes one outstanding read, latency set by the bench.
`timescale 1ns/1ns
module hptw_mem_model
(
  input  wire logic         clk_i,
  input  wire logic         mem_req_i,
  input  wire logic [63:0]  mem_addr_i,
  input  wire logic [63:0]  hit_addr_i,
  input  wire logic [127:0] hit_data_i,
  input  wire logic [127:0] decoy_flip_i,
  input  wire logic [1:0]   delay_i,
  output logic              mem_valid_o,
  output logic [127:0]      mem_data_o
);
  logic [1:0] wait_cnt = 2'h0;
  initial mem_valid_o = 1'h0;
  initial mem_data_o = '0;
  always @(posedge clk_i)
  begin
    mem_valid_o <= 1'h0;
    mem_data_o  <= ~mem_data_o; // idle bus inverts each cycle, so a stale entry never stays two cycles in a row
    if (mem_req_i && !mem_valid_o)
    begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt >= delay_i)
      begin
        wait_cnt    <= 2'h0;
        mem_valid_o <= 1'h1;
        // addresses compared as physical; decoys differ only in valid or select flag
        mem_data_o  <= (mem_addr_i === hit_addr_i) ? hit_data_i : hit_data_i ^ decoy_flip_i;
      end
    end
  end
endmodule

//--- testbench/hptw_walker_tb.sv
// hptw_walker_tb: random walks over both layouts, hits and faults.
// assumes the register map and entry layout of hptw_pkg.
`timescale 1ns/1ns
module hptw_walker_tb;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, mv = 1'h0, mi = 1'h0, ce = 1'h1;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0, q, wb_dat_o;
  logic [38:0] sid = '0;
  logic [15:0] pidx = 16'h0;
  logic [63:0] haddr = '1, d, r, mem_addr_o, fill_entry_o;
  logic [127:0] hdata = '0, flip = '0, mem_data;
  logic [1:0] dly = 2'h0;
  logic [27:0] m;
  logic [8:0] m9;
  logic wb_ack_o, miss_ready_o, mem_req_o, mem_valid, fill_valid_o, fault_instr_o, fault_data_o, w, sec, miss;
  int n_mismatch = 0, checks = 0, rd_cnt = 0, n, t, slot;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (mem_valid === 1'h1) rd_cnt++;
  hptw_walker hptw_walker_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .miss_valid_i(mv), .miss_instr_i(mi), .miss_segment_identifier_i(sid), .miss_page_index_i(pidx),
    .miss_ready_o(miss_ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_coherent_o(),
    .mem_valid_i(mem_valid), .mem_data_i(mem_data), .fill_valid_o(fill_valid_o), .fill_entry_o(fill_entry_o),
    .resume_o(), .fault_instr_o(fault_instr_o), .fault_data_o(fault_data_o));
  hptw_mem_model hptw_mem_model_inst (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .hit_addr_i(haddr), .hit_data_i(hdata), .decoy_flip_i(flip), .delay_i(dly), .mem_valid_o(mem_valid),
    .mem_data_o(mem_data));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] grp(input logic wd, input logic [63:0] dd, input logic sc);
    logic [38:0] h = wd ? sid ^ {23'h0, pidx} : {20'h0, sid[18:0] ^ {3'h0, pidx}};
    logic [27:0] mk = (28'h1 << dd[4:0]) - 28'h1;
    if (sc) h = ~h;
    if (wd) return {dd[63:46], dd[45:18] | (h[38:11] & mk), h[10:0], 7'h0};
    return {32'h0, dd[31:25], dd[24:16] | (h[18:10] & dd[8:0]), h[9:0], 6'h0};
  endfunction
  function automatic logic [127:0] ent(input logic wd, input logic sc);
    if (wd) return {sid, pidx[15:3], 10'h0, sc, 1'h1, r};
    return {2'h2, pidx[15:12], sc, sid[18:0], 6'h0, r[31:0], 64'h0};
  endfunction
  task automatic chk(input logic c, input string s);
    checks++;
    if (c !== 1'h1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask
  task automatic wb_x(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'h3, wr, a, v};
    t = 0;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++t < 50);
    q = wb_dat_o;
    {cyc, stb} <= 2'h0;
    if (t >= 50) chk(1'h0, "no ack");
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(41));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    wb_x(1'h0, 8'h20, 32'h0);
    chk(q === 32'h0, "unmapped read");
    for (n = 0; n < 12; n++)
    begin
      {w, sec, slot, miss} = {1'($urandom), 1'($urandom), $urandom % 8, 1'(n % 4 == 3)};
      if (n < 2) {w, sec, slot} = {1'(n), 1'h1, 32'h7};
      {d, r, sid, pidx, dly, mi} = 186'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      m = (28'h1 << ($urandom % 29)) - 28'h1;
      m9 = (9'h1 << ($urandom % 10)) - 9'h1;
      if (w) d = {d[63:46], d[45:18] & ~m, 13'h0, 5'($countones(m))};
      else d = {32'h0, d[31:25], d[24:16] & ~m9, 7'h0, m9};
      // mode first: a mode switch clears the reserved bits of the new layout
      wb_x(1'h1, hptw_pkg::ADDR_CTRL, {31'h0, w});
      wb_x(1'h1, hptw_pkg::ADDR_DESC_LO, d[31:0]);
      wb_x(1'h1, hptw_pkg::ADDR_DESC_HI, d[63:32]);
      wb_x(1'h0, hptw_pkg::ADDR_DESC_LO, 32'h0);
      chk(q === d[31:0], "descriptor readback");
      wb_x(1'h0, hptw_pkg::ADDR_DESC_HI, 32'h0);
      chk(q === d[63:32], "descriptor high readback");
      haddr = miss ? '1 : grp(w, d, sec) + 64'(slot << (w ? 4 : 3));
      hdata = ent(w, sec);
      flip = 128'h1 << ((miss || sec) ? (w ? 64 : 127) : (w ? 65 : 121));
      rd_cnt = 0;
      @(posedge clk_i);
      {mv, ce} <= 2'h2;
      repeat (4) @(posedge clk_i);
      chk(miss_ready_o === 1'h1 && mem_req_o === 1'h0, "request taken while frozen");
      ce <= 1'h1;
      do @(posedge clk_i); while (miss_ready_o !== 1'h1);
      mv <= 1'h0;
      t = 0;
      do @(posedge clk_i); while (fill_valid_o !== 1'h1 && fault_data_o !== 1'h1 && fault_instr_o !== 1'h1
        && ++t < 400);
      chk(fill_valid_o === !miss, "hit result");
      chk(rd_cnt == (miss ? 16 : 8 * sec + slot + 1), "read count");
      if (miss) chk({fault_instr_o, fault_data_o} === {mi, !mi}, "fault kind");
      else chk(fill_entry_o === (w ? r : {32'h0, r[31:0]}), "fill entry");
      wb_x(1'h0, hptw_pkg::ADDR_STATUS, 32'h0);
      chk(q[3:0] === (miss ? 4'hC : {sec, 3'h2}), "status");
      wb_x(1'h0, hptw_pkg::ADDR_RESULT_LO, 32'h0);
      if (!miss) chk(q === r[31:0], "result register");
      wb_x(1'h0, hptw_pkg::ADDR_RESULT_HI, 32'h0);
      if (!miss) chk(q === (w ? r[63:32] : 32'h0), "result high register");
      $display("test %0d done", n);
    end
    final_report();
  end
endmodule
